// ---- rtl/ssv_supervisor.sv ----
`timescale 1ns/1ps
// Function
// [RULE1] Six rail fault inputs, each judged separately
// [RULE2] Start: reset on, irq off, await rails
// [RULE3] Hold reset stretch time after rails good
// [RULE4] Stretch programmable 32 us to 2 s
// [RULE5] Rail fault after release reasserts reset
// [RULE6] Watchdog expiry without kick fall raises irq
// [RULE7] Processor kicks before each timeout
// [RULE8] Watchdog timeout programmable 32 us upward
// [RULE9] Manual reset held past debounce forces reset
// [RULE10] Debounce programmable 32 us to 2 s
// [RULE11] Per-rail 64 us glitch filter
// [RULE12] All rails checked in parallel, fast
// [RULE13] Any rail selectable as over-voltage
// [RULE14] Core rails reset, others only interrupt
// [RULE15] Kick fall restarts watchdog; cleared in reset
// [RULE16] After stretch: release, arm watchdog, monitor
module ssv_supervisor
    import ssv_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [5:0]  rail_raw_in,
    input  wire logic        manual_rst_n_in,
    input  wire logic        watchdog_kick_in,
    output logic             cpu_rst_n_out,
    output logic             watchdog_irq_out,
    output logic             irq_out,
    output logic             shutdown_out
);

    ssv_cfg_t     cfg_q;
    logic [31:0]  stretch_q;
    logic [31:0]  wdog_q;
    logic [31:0]  debounce_q;
    logic [IRQ_W-1:0] sts_q;
    logic [IRQ_W-1:0] msk_q;
    logic [5:0]   rail_clean;
    logic [5:0]   fault;
    logic         core_fault;
    logic [15:0]  tick_cnt_q;
    logic         tick;
    ssv_state_t   state_q;
    logic [31:0]  st_cnt_q;
    logic [31:0]  db_cnt_q;
    logic         mrst_q;
    logic         mrst_d;
    logic [2:0]   mr_sync_q;
    logic [2:0]   kk_sync_q;
    logic         kick_lvl_q;
    logic         kick_fall;
    logic [31:0]  wd_cnt_q;
    logic         wd_expire;
    logic         wr_en;
    logic         rd_en;
    logic         rst_active;

    // ------------------------------------------------------------
    // Rail filtering and fault decode
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_RAILS; gi++) begin : g_rail
            ssv_glitch_filter u_filt (
                .pclk    (pclk),
                .presetn (presetn),
                .raw_in  (rail_raw_in[gi]),
                .clean_q (rail_clean[gi])
            ); // [RULE11] [RULE12]
            // Input high means above threshold
            assign fault[gi] = cfg_q.over_volt[gi] ? rail_clean[gi]
                                                   : ~rail_clean[gi]; // [RULE13] [RULE1]
        end
    endgenerate

    assign core_fault = |(fault & cfg_q.core); // [RULE14]

    // ------------------------------------------------------------
    // 32 us timebase
    // ------------------------------------------------------------
    assign tick = (tick_cnt_q == 16'(TICK_CYC - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_q <= 16'h0000;
        end else if (tick) begin
            tick_cnt_q <= 16'h0000;
        end else begin
            tick_cnt_q <= tick_cnt_q + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mr_sync_q  <= 3'h7;
            kk_sync_q  <= 3'h0;
            kick_lvl_q <= 1'b0;
        end else begin
            mr_sync_q <= {mr_sync_q[1:0], manual_rst_n_in};
            kk_sync_q <= {kk_sync_q[1:0], watchdog_kick_in};
            if (kk_sync_q[2] == kk_sync_q[1]) begin
                kick_lvl_q <= kk_sync_q[2];
            end
        end
    end

    assign kick_fall = kick_lvl_q && (kk_sync_q[2] == kk_sync_q[1])
                       && !kk_sync_q[2];

    // ------------------------------------------------------------
    // Manual reset debounce
    // ------------------------------------------------------------
    always_comb begin
        mrst_d = mrst_q;
        if (mr_sync_q[2] != mr_sync_q[1]) begin
            mrst_d = mrst_q;
        end else if (mr_sync_q[2]) begin
            mrst_d = 1'b0;
        end else if (tick && db_cnt_q >= debounce_q) begin
            mrst_d = 1'b1; // [RULE9]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            db_cnt_q <= 32'h0000_0000;
            mrst_q   <= 1'b0;
        end else begin
            mrst_q <= mrst_d;
            if (mr_sync_q[2]) begin
                db_cnt_q <= 32'h0000_0000; // [RULE9]
            end else if (tick && db_cnt_q < debounce_q) begin
                db_cnt_q <= db_cnt_q + 32'h0000_0001; // [RULE10]
            end
        end
    end

    // ------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q  <= ST_WAIT_GOOD; // [RULE2]
            st_cnt_q <= 32'h0000_0000;
        end else begin
            unique case (state_q)
                ST_WAIT_GOOD: begin
                    st_cnt_q <= 32'h0000_0000;
                    if (!core_fault && !mrst_q) begin
                        state_q <= ST_STRETCH; // [RULE2]
                    end
                end
                ST_STRETCH: begin
                    if (core_fault || mrst_q) begin
                        state_q <= ST_WAIT_GOOD;
                    end else if (tick) begin
                        if (st_cnt_q + 32'h0000_0001 >= stretch_q) begin
                            state_q <= ST_RUN; // [RULE3] [RULE16]
                        end
                        st_cnt_q <= st_cnt_q + 32'h0000_0001; // [RULE4]
                    end
                end
                ST_RUN: begin
                    if (core_fault || mrst_q) begin
                        state_q <= ST_WAIT_GOOD; // [RULE5] [RULE9]
                    end
                end
            endcase
        end
    end

    assign rst_active = (state_q != ST_RUN);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_rst_n_out <= 1'b0;
            shutdown_out  <= 1'b0;
        end else begin
            cpu_rst_n_out <= !(rst_active || core_fault || mrst_q); // [RULE5]
            if (state_q == ST_RUN && core_fault) begin
                shutdown_out <= 1'b1; // [RULE14]
            end else if (state_q == ST_STRETCH) begin
                shutdown_out <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    assign wd_expire = tick && (wd_cnt_q + 32'h0000_0001 >= wdog_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_cnt_q         <= 32'h0000_0000;
            watchdog_irq_out <= 1'b0;
        end else if (rst_active) begin
            wd_cnt_q         <= 32'h0000_0000; // [RULE15]
            watchdog_irq_out <= 1'b0; // [RULE2]
        end else if (kick_fall) begin
            wd_cnt_q         <= 32'h0000_0000; // [RULE15] [RULE7]
            watchdog_irq_out <= 1'b0;
        end else if (wd_expire) begin
            watchdog_irq_out <= 1'b1; // [RULE6]
        end else if (tick && !watchdog_irq_out) begin
            wd_cnt_q <= wd_cnt_q + 32'h0000_0001; // [RULE8]
        end
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q      <= '{over_volt: RST_OV, core: RST_CORE};
            stretch_q  <= RST_STRETCH;
            wdog_q     <= RST_WDOG;
            debounce_q <= RST_DEBOUNCE;
            msk_q      <= RST_MSK;
        end else if (wr_en) begin
            unique case (paddr)
                OFS_CTRL: begin
                    cfg_q.over_volt <= pwdata[CTRL_OV_LSB +: 6]; // [RULE13]
                    cfg_q.core      <= pwdata[CTRL_CORE_LSB +: 6];
                end
                OFS_STRETCH: begin
                    stretch_q <= (pwdata == 32'h0000_0000) ? 32'h0000_0001
                               : (pwdata > TICKS_2S) ? TICKS_2S : pwdata; // [RULE4]
                end
                OFS_WDOG: begin
                    wdog_q <= (pwdata == 32'h0000_0000) ? 32'h0000_0001
                            : (pwdata > TICKS_MAX) ? TICKS_MAX : pwdata; // [RULE8]
                end
                OFS_DEBOUNCE: begin
                    debounce_q <= (pwdata == 32'h0000_0000) ? 32'h0000_0001
                                : (pwdata > TICKS_2S) ? TICKS_2S : pwdata; // [RULE10]
                end
                OFS_IRQ_MSK: msk_q <= pwdata[IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // Sticky events; set wins over write-one-to-clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sts_q <= '0;
        end else begin
            sts_q <= (sts_q & ~((wr_en && paddr == OFS_IRQ_STS)
                                ? pwdata[IRQ_W-1:0] : '0))
                     | {mrst_d && !mrst_q,
                        wd_expire && !rst_active && !kick_fall
                                  && !watchdog_irq_out,
                        fault & ~cfg_q.core}; // [RULE14]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(sts_q & msk_q);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                pslverr <= !(paddr inside {OFS_CTRL, OFS_STRETCH, OFS_WDOG,
                             OFS_DEBOUNCE, OFS_STATUS, OFS_IRQ_STS,
                             OFS_IRQ_MSK});
            end
            if (rd_en) begin
                unique case (paddr)
                    OFS_CTRL:     prdata <= {18'h0_0000, cfg_q.core,
                                             2'h0, cfg_q.over_volt};
                    OFS_STRETCH:  prdata <= stretch_q;
                    OFS_WDOG:     prdata <= wdog_q;
                    OFS_DEBOUNCE: prdata <= debounce_q;
                    OFS_STATUS:   prdata <= {16'h0000, state_q,
                                             mrst_q, watchdog_irq_out,
                                             fault, rail_clean};
                    OFS_IRQ_STS:  prdata <= {24'h0, sts_q};
                    OFS_IRQ_MSK:  prdata <= {24'h0, msk_q};
                    default:      prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule

// ---- rtl/ssv_pkg.sv ----
package ssv_pkg;

    localparam int NUM_RAILS = 6;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ        = 100;
    localparam int TICK_US        = 32;
    localparam int TICK_CYC       = TICK_US * CLK_MHZ;
    localparam int GLITCH_US      = 64;
    localparam int GLITCH_TICKS   = GLITCH_US / TICK_US;
    localparam int GLITCH_CYC     = GLITCH_US * CLK_MHZ;
    localparam int DETECT_US      = 12;
    localparam int DETECT_CYC     = DETECT_US * CLK_MHZ;
    // Stretch and debounce: 32 us .. 2 s in 32 us ticks
    localparam int STRETCH_MS_DEF = 200;
    localparam int DEBOUNCE_MS_DEF = 50;
    localparam int WDOG_MS_DEF    = 1000;
    localparam logic [31:0] TICKS_2S  = 32'h0000_F424;
    localparam logic [31:0] TICKS_MAX = 32'h0FFF_FFFF;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_CTRL     = 12'h000;
    localparam logic [11:0] OFS_STRETCH  = 12'h004;
    localparam logic [11:0] OFS_WDOG     = 12'h008;
    localparam logic [11:0] OFS_DEBOUNCE = 12'h00C;
    localparam logic [11:0] OFS_STATUS   = 12'h010;
    localparam logic [11:0] OFS_IRQ_STS  = 12'h014;
    localparam logic [11:0] OFS_IRQ_MSK  = 12'h018;

    localparam int CTRL_OV_LSB   = 0;
    localparam int CTRL_CORE_LSB = 8;
    localparam logic [5:0] RST_OV   = 6'h00;
    localparam logic [5:0] RST_CORE = 6'h3F;
    localparam logic [31:0] RST_STRETCH  = 32'h0000_186A;
    localparam logic [31:0] RST_WDOG     = 32'h0000_7A12;
    localparam logic [31:0] RST_DEBOUNCE = 32'h0000_061A;
    localparam logic [7:0]  RST_MSK      = 8'h00;

    // Interrupt status bit positions
    localparam int IRQ_WDOG = 6;
    localparam int IRQ_MRST = 7;
    localparam int IRQ_W    = 8;

    typedef struct packed {
        logic [5:0] over_volt;
        logic [5:0] core;
    } ssv_cfg_t;

    typedef enum logic [1:0] {
        ST_WAIT_GOOD,
        ST_STRETCH,
        ST_RUN
    } ssv_state_t;

endpackage

// ---- rtl/ssv_glitch_filter.sv ----
`timescale 1ns/1ps
module ssv_glitch_filter
    import ssv_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic raw_in,
    output logic      clean_q
);

    logic [2:0]  sync_q;
    logic [15:0] cnt_q;

    // ------------------------------------------------------------
    // Three-stage synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_q <= 3'h0;
        end else begin
            sync_q <= {sync_q[1:0], raw_in};
        end
    end

    // ------------------------------------------------------------
    // Level must stand the full filter time to pass
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q   <= 16'h0000;
            clean_q <= 1'b0;
        end else if (sync_q[2] != sync_q[1] || sync_q[2] == clean_q) begin
            cnt_q <= 16'h0000;
        end else if (cnt_q == 16'(GLITCH_CYC - 1)) begin
            cnt_q   <= 16'h0000;
            clean_q <= sync_q[2];
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

endmodule

// ---- verif/ssv_host_model.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// Host processor: kicks the watchdog while out of reset
// ------------------------------------------------------------
module ssv_host_model #(
    parameter int HALF = 1000
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic kick_en,
    input  wire logic cpu_rst_n_out,
    output logic      watchdog_kick_in
);
    int cnt_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q            <= 0;
            watchdog_kick_in <= 1'b0;
        end else if (kick_en && cpu_rst_n_out) begin
            if (cnt_q == HALF - 1) begin
                cnt_q            <= 0;
                watchdog_kick_in <= ~watchdog_kick_in;
            end else begin
                cnt_q <= cnt_q + 1;
            end
        end
    end
endmodule

// ---- verif/ssv_sup_asserts.sv ----
`timescale 1ns/1ps
module ssv_sup_asserts (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [5:0]  rail_raw_in,
    input wire logic        manual_rst_n_in,
    input wire logic        watchdog_kick_in,
    input wire logic        cpu_rst_n_out,
    input wire logic        watchdog_irq_out
);
    // ------------------------------------------------------------
    // Run-length counters
    // ------------------------------------------------------------
    logic [15:0] fcnt_q, gcnt_q, mcnt_q, kcnt_q;

    function automatic logic [15:0] inc(input logic [15:0] v);
        return (v == 16'hFFFF) ? v : v + 16'h0001;
    endfunction

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fcnt_q <= '0;
            gcnt_q <= '0;
            mcnt_q <= '0;
            kcnt_q <= '0;
        end else begin
            fcnt_q <= (&rail_raw_in) ? '0 : inc(fcnt_q);
            gcnt_q <= (&rail_raw_in) ? inc(gcnt_q) : '0;
            mcnt_q <= manual_rst_n_in ? '0 : inc(mcnt_q);
            kcnt_q <= (!cpu_rst_n_out || $fell(watchdog_kick_in)) ?
                      '0 : inc(kcnt_q);
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence held_off;
        (!cpu_rst_n_out && !watchdog_irq_out) [*8];
    endsequence

    a_start_hold: assert property ($rose(presetn) |-> held_off)
        else $error("reset not held after start");
    a_stretch_min: assert property ($rose(cpu_rst_n_out)
        |-> gcnt_q >= 16'h1900) else $error("reset released early");
    a_fault_rst: assert property (fcnt_q >= 16'h190A
        |-> !cpu_rst_n_out) else $error("rail fault missed");
    a_glitch_rej: assert property ($fell(cpu_rst_n_out)
        |-> fcnt_q >= 16'h189C || mcnt_q >= 16'h0008)
        else $error("reset on short pulse");
    a_wdog_run: assert property ($rose(watchdog_irq_out)
        |-> $past(cpu_rst_n_out)) else $error("watchdog in reset");
    a_wdog_kick: assert property ($rose(watchdog_irq_out)
        |-> kcnt_q >= 16'h0008) else $error("watchdog after kick");
    a_kick_clear: assert property ($fell(watchdog_kick_in)
        |-> ##[1:8] !watchdog_irq_out) else $error("kick ignored");
    a_apb_ready: assert property (psel && !penable |=> pready)
        else $error("no ready in access");
    a_ready_once: assert property (pready |=> !pready)
        else $error("ready too long");
    a_apb_err: assert property (psel && pready && paddr > 12'h018
        |-> pslverr) else $error("unmapped not refused");
endmodule

// ---- verif/tb_supply_supervisor_reset_watchdog.sv ----
`timescale 1ns/1ps
module tb_supply_supervisor_reset_watchdog import ssv_pkg::*;;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0]  rail_raw_in;
    logic        manual_rst_n_in, watchdog_kick_in, kick_en, err;
    logic        cpu_rst_n_out, watchdog_irq_out, irq_out, shutdown_out;
    logic [77:0] rows [10];
    int          fails, n_compared, n;

    ssv_supervisor uut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rail_raw_in(rail_raw_in),
        .manual_rst_n_in(manual_rst_n_in),
        .watchdog_kick_in(watchdog_kick_in),
        .cpu_rst_n_out(cpu_rst_n_out),
        .watchdog_irq_out(watchdog_irq_out), .irq_out(irq_out),
        .shutdown_out(shutdown_out));
    ssv_host_model host (.pclk(pclk), .presetn(presetn),
        .kick_en(kick_en), .cpu_rst_n_out(cpu_rst_n_out),
        .watchdog_kick_in(watchdog_kick_in));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] s, e);
        n_compared++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s exp %h seen %h", nm, e, s);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i >= 50) check("pready", 32'h0, 32'h1);
        if (i >= 50) end_of_test();
    endtask

    task automatic wait_sig(input logic w, v, input int lim);
        n = 0;
        while (((w ? watchdog_irq_out : cpu_rst_n_out) !== v)
               && n < lim) begin
            @(posedge pclk);
            n++;
        end
        if (n >= lim) check("wait", {31'h0, ~v}, {31'h0, v});
        if (n >= lim) end_of_test();
    endtask

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = '0; pwdata = '0; rail_raw_in = '0; kick_en = 1'b1;
        manual_rst_n_in = 1'b1; fails = 0; n_compared = 0;
        rows[0] = {1'b0, OFS_CTRL, 32'h0, 32'h0000_3F00, 1'b0};
        rows[1] = {1'b0, OFS_STRETCH, 32'h0, RST_STRETCH, 1'b0};
        rows[2] = {1'b0, OFS_WDOG, 32'h0, RST_WDOG, 1'b0};
        rows[3] = {1'b0, OFS_DEBOUNCE, 32'h0, RST_DEBOUNCE, 1'b0};
        rows[4] = {1'b0, OFS_IRQ_MSK, 32'h0, 32'h0, 1'b0};
        rows[5] = {1'b0, 12'h01C, 32'h0, 32'h0, 1'b1};
        rows[6] = {1'b1, OFS_STRETCH, TICKS_2S, TICKS_2S, 1'b0};
        rows[7] = {1'b1, OFS_WDOG, TICKS_MAX, TICKS_MAX, 1'b0};
        rows[8] = {1'b1, OFS_DEBOUNCE, TICKS_2S, TICKS_2S, 1'b0};
        rows[9] = {1'b1, 12'h01C, 32'hFFFF_FFFF, 32'h0, 1'b1};
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i][77]) apb(1'b1, rows[i][76:65], rows[i][64:33]);
            apb(1'b0, rows[i][76:65], 32'h0);
            check("reg", rd, rows[i][32:1]);
            check("slverr", {31'h0, err}, {31'h0, rows[i][0]});
        end
        $display("test registers done");
        apb(1'b1, OFS_STRETCH, 32'h0000_0002);
        apb(1'b1, OFS_WDOG, 32'h0000_0003);
        apb(1'b1, OFS_DEBOUNCE, 32'h0000_0002);
        apb(1'b1, OFS_IRQ_MSK, 32'h0000_00FF);
        check("rst_low", {31'h0, cpu_rst_n_out}, 32'h0);
        @(posedge pclk);
        rail_raw_in <= 6'h3F;
        wait_sig(1'b0, 1'b1, 20000);
        check("release", 32'(n >= 9600 && n <= 12900), 32'h1);
        $display("test powerup done");
        repeat (15000) @(posedge pclk);
        check("no_wdog", {31'h0, watchdog_irq_out}, 32'h0);
        kick_en <= 1'b0;
        wait_sig(1'b1, 1'b1, 12000);
        check("wdog_time", 32'(n >= 4400), 32'h1);
        @(posedge pclk);
        check("irq", {31'h0, irq_out}, 32'h1);
        apb(1'b0, OFS_IRQ_STS, 32'h0);
        check("sts_wdog", rd, 32'h0000_0040);
        kick_en <= 1'b1;
        wait_sig(1'b1, 1'b0, 3000);
        apb(1'b1, OFS_IRQ_STS, 32'h0000_0040);
        apb(1'b0, OFS_IRQ_STS, 32'h0);
        check("sts_clr", rd, 32'h0);
        check("irq_clr", {31'h0, irq_out}, 32'h0);
        $display("test watchdog done");
        manual_rst_n_in <= 1'b0;
        repeat (3000) @(posedge pclk);
        manual_rst_n_in <= 1'b1;
        repeat (100) @(posedge pclk);
        check("short_mr", {31'h0, cpu_rst_n_out}, 32'h1);
        manual_rst_n_in <= 1'b0;
        wait_sig(1'b0, 1'b0, 12000);
        check("mr_time", 32'(n >= 3200), 32'h1);
        manual_rst_n_in <= 1'b1;
        wait_sig(1'b0, 1'b1, 10000);
        $display("test manual done");
        rail_raw_in <= 6'h3B;
        repeat (3000) @(posedge pclk);
        rail_raw_in <= 6'h3F;
        repeat (100) @(posedge pclk);
        check("glitch", {31'h0, cpu_rst_n_out}, 32'h1);
        rail_raw_in <= 6'h3E;
        wait_sig(1'b0, 1'b0, 8000);
        check("fault", 32'(n >= 6395 && n <= 6415), 32'h1);
        repeat (2) @(posedge pclk);
        check("shutdown", {31'h0, shutdown_out}, 32'h1);
        rail_raw_in <= 6'h3F;
        wait_sig(1'b0, 1'b1, 20000);
        $display("test fault done");
        apb(1'b1, OFS_CTRL, 32'h0000_1F20);
        apb(1'b1, OFS_IRQ_STS, 32'h0000_00FF);
        repeat (100) @(posedge pclk);
        check("ov_rst", {31'h0, cpu_rst_n_out}, 32'h1);
        check("ov_irq", {31'h0, irq_out}, 32'h1);
        apb(1'b0, OFS_IRQ_STS, 32'h0);
        check("ov_sts", rd, 32'h0000_0020);
        $display("test overvolt done");
        end_of_test();
    end
endmodule

bind ssv_supervisor ssv_sup_asserts u_chk (.pclk(pclk),
    .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr),
    .rail_raw_in(rail_raw_in), .manual_rst_n_in(manual_rst_n_in),
    .watchdog_kick_in(watchdog_kick_in),
    .cpu_rst_n_out(cpu_rst_n_out),
    .watchdog_irq_out(watchdog_irq_out));
